// ===== hw/rxb_pkg.sv
/*
  Shared constants and types for the receive error counter and self-test control block.
  Assumes the register port carries the documented register addresses directly.
*/
package rxb_pkg;

  // ----------------------------------------------------------------
  // Register port geometry and addresses.
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W          = 8;
  localparam int unsigned DATA_W          = 16;
  localparam logic [7:0]  ADDR_RX_ERR     = 8'h15;
  localparam logic [7:0]  ADDR_SELF_TEST  = 8'h16;
  localparam logic [7:0]  ADDR_CHK_COUNT  = 8'h19;
  localparam logic [7:0]  ADDR_IRQ_STATUS = 8'h1a;
  localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h1b;

  // ----------------------------------------------------------------
  // Self-test control field positions and reset value.
  // ----------------------------------------------------------------
  localparam int unsigned  BIT_WRAP_MODE   = 14;
  localparam int unsigned  BIT_CFG_HI      = 13;
  localparam int unsigned  BIT_CFG_LO      = 12;
  localparam int unsigned  BIT_LOCKED      = 11;
  localparam int unsigned  BIT_SYNC_LOST   = 10;
  localparam int unsigned  BIT_GEN_STATUS  = 9;
  localparam int unsigned  BIT_POWER_MODE  = 8;
  localparam logic [15:0]  SELF_TEST_RESET = 16'h0100;

  // ----------------------------------------------------------------
  // Receive error counter limits and checker error counter width.
  // ----------------------------------------------------------------
  localparam int unsigned  RX_ERR_W    = 16;
  localparam logic [15:0]  RX_ERR_MAX  = 16'h00ff;
  localparam logic [15:0]  RX_ERR_HALF = 16'h007f;
  localparam int unsigned  CHK_CNT_W   = 8;

  // ----------------------------------------------------------------
  // Interrupt status bit positions.
  // ----------------------------------------------------------------
  localparam int unsigned IRQ_RX_HALF   = 0;
  localparam int unsigned IRQ_CHK_WRAP  = 1;
  localparam int unsigned IRQ_SYNC_LOST = 2;
  localparam int unsigned IRQ_W         = 3;

  // Pattern test configuration codes.
  typedef enum logic [1:0] {
    CFG_OFF    = 2'h0,
    CFG_SINGLE = 2'h1,
    CFG_CHECK  = 2'h2,
    CFG_CONT   = 2'h3
  } rxb_cfg_t;

  // Generator control states, one-hot.
  typedef enum logic [3:0] {
    GS_IDLE   = 4'h1,
    GS_SINGLE = 4'h2,
    GS_SENT   = 4'h4,
    GS_CONT   = 4'h8
  } rxb_gen_state_t;

endpackage : rxb_pkg

// ===== hw/rxb_rx_err_count.sv
/*
  Saturating receive error counter with clear-on-read and half-full event.
  Assumes error qualifiers are synchronous one-cycle pulses per symbol error.
*/
`timescale 1ns/10ps
module rxb_rx_err_count (
  // Clock and reset.
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  // Error qualifiers.
  input  wire logic                         err_in,
  input  wire logic                         loopback_in,
  input  wire logic                         clear_in,
  // Results.
  output logic [rxb_pkg::RX_ERR_W-1:0]      count_out,
  output logic                              half_evt_out
);

  logic [rxb_pkg::RX_ERR_W-1:0] base;
  logic                         inc;

  // Clear first, so an error in the read cycle still counts.
  always_comb begin
    base = clear_in ? '0 : count_out;
    inc  = err_in && !loopback_in && (base != rxb_pkg::RX_ERR_MAX);
  end

  // Counter register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_out <= '0;
    end else begin
      count_out <= inc ? base + 16'h0001 : base;
    end
  end

  // One pulse when the count first rises past half-full.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      half_evt_out <= 1'b0;
    end else begin
      half_evt_out <= inc && (base == rxb_pkg::RX_ERR_HALF);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_rx_count_step: assert property (err_in && !loopback_in && !clear_in && count_out < rxb_pkg::RX_ERR_MAX
    |=> count_out == $past(count_out) + 16'h0001) else $error("rx count did not step");
  chk_rx_loop_hold: assert property (loopback_in && !clear_in |=> $stable(count_out))
    else $error("rx count moved in loopback");
  chk_rx_saturate: assert property (count_out == rxb_pkg::RX_ERR_MAX && !clear_in
    |=> count_out == rxb_pkg::RX_ERR_MAX) else $error("rx count left saturation");
  chk_rx_half_event: assert property (half_evt_out |-> count_out == rxb_pkg::RX_ERR_HALF + 16'h0001)
    else $error("half-full event at wrong count");

endmodule : rxb_rx_err_count

// ===== hw/rxb_chk_err_count.sv
/*
  Pattern checker error counter with stop or wrap-with-pulse mode.
  Assumes checker error indications are one-cycle synchronous pulses.
*/
`timescale 1ns/10ps
module rxb_chk_err_count #(
  parameter int unsigned W = rxb_pkg::CHK_CNT_W
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Control.
  input  wire logic         enable_in,
  input  wire logic         err_in,
  input  wire logic         wrap_mode_in,
  input  wire logic         clear_in,
  // Results.
  output logic [W-1:0]      count_out,
  output logic              wrap_pulse_out
);

  logic [W-1:0] base;
  logic         hit;
  logic         at_max;

  always_comb begin
    base   = clear_in ? '0 : count_out;
    hit    = enable_in && err_in;
    at_max = &base;
  end

  // Single mode parks at the top; continuous mode wraps to zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_out      <= '0;
      wrap_pulse_out <= 1'b0;
    end else begin
      wrap_pulse_out <= hit && at_max && wrap_mode_in;
      if (hit && !at_max) begin
        count_out <= base + {{(W-1){1'b0}}, 1'b1};
      end else if (hit && wrap_mode_in) begin
        count_out <= '0;
      end else begin
        count_out <= base;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_chk_stop_max: assert property (!wrap_mode_in && !clear_in && (&count_out) |=> (&count_out))
    else $error("checker count left its top in single mode");
  chk_chk_wrap_pulse: assert property (wrap_mode_in && hit && !clear_in && (&count_out)
    |=> wrap_pulse_out && count_out == '0) else $error("checker count did not wrap with pulse");

endmodule : rxb_chk_err_count

// ===== hw/rxb_top.sv
/*
  Receive error counting and pattern self-test control, with its register port and interrupt.
  Assumes the pattern generator and checker datapaths sit outside and exchange levels and
  one-cycle pulses on this clock; all inputs are synchronous to MCLK_IN.
*/
// Added by the designer: strobed register access.
// Function
// - Count each invalid-symbol receive error while carrier and data valid are present.
// - Hold the receive error count unchanged during MII loopback.
// - Receive error count saturates at FFh instead of wrapping.
// - Raise an interrupt event when the count passes 7Fh.
// - Reading the receive error count returns it, then clears it.
// - Single mode: checker error count stops at its maximum.
// - Continuous mode: at maximum, pulse and restart checker count from zero.
// - Config 0 disables generator and checker; config 2 enables checker only.
// - Config 1 sends one constant-data packet; checker stays off.
// - Config 3 enables checker and continuous packet generation.
// - Status bit 11 shows checker locked on the received stream.
// - Status bit 10 sets when the checker loses sync.
// - Status bit 9 shows the packet generator active.
`timescale 1ns/10ps
module rxb_top (
  // Clock and reset.
  input  wire logic                       MCLK_IN,
  input  wire logic                       RST_N_IN,
  // Register port.
  input  wire logic [rxb_pkg::ADDR_W-1:0] ADDR_IN,
  input  wire logic [rxb_pkg::DATA_W-1:0] WDATA_IN,
  input  wire logic                       WR_IN,
  input  wire logic                       RD_IN,
  output logic [rxb_pkg::DATA_W-1:0]      RDATA_OUT,
  // Receive path qualifiers.
  input  wire logic                       CARRIER_VALID_IN,
  input  wire logic                       RX_DV_IN,
  input  wire logic                       SYMBOL_ERR_IN,
  input  wire logic                       MII_LOOPBACK_IN,
  // Pattern checker datapath.
  input  wire logic                       CHK_LOCKED_IN,
  input  wire logic                       CHK_SYNC_LOSS_IN,
  input  wire logic                       CHK_BIT_ERR_IN,
  output logic                            CHECKER_EN_OUT,
  output logic                            CHK_WRAP_PULSE_OUT,
  // Packet generator datapath.
  input  wire logic                       GEN_PKT_DONE_IN,
  output logic                            GEN_RUN_OUT,
  output logic                            GEN_CONT_OUT,
  // Interrupt.
  output logic                            IRQ_OUT
);

  // ----------------------------------------------------------------
  // Register strobes.
  // ----------------------------------------------------------------
  logic rd_rx_err;
  logic rd_self_test;
  logic rd_chk_count;
  logic wr_self_test;
  logic wr_irq_status;
  logic wr_irq_mask;

  // Decode each strobe against its address once.
  // Reads and writes never overlap, so each decode stands alone.
  always_comb begin
    rd_rx_err     = RD_IN && (ADDR_IN == rxb_pkg::ADDR_RX_ERR);
    rd_self_test  = RD_IN && (ADDR_IN == rxb_pkg::ADDR_SELF_TEST);
    rd_chk_count  = RD_IN && (ADDR_IN == rxb_pkg::ADDR_CHK_COUNT);
    wr_self_test  = WR_IN && (ADDR_IN == rxb_pkg::ADDR_SELF_TEST);
    wr_irq_status = WR_IN && (ADDR_IN == rxb_pkg::ADDR_IRQ_STATUS);
    wr_irq_mask   = WR_IN && (ADDR_IN == rxb_pkg::ADDR_IRQ_MASK);
  end

  // ----------------------------------------------------------------
  // Self-test control fields.
  // ----------------------------------------------------------------
  rxb_pkg::rxb_cfg_t cfg;
  logic              wrap_mode;
  logic              sync_lost;
  logic              chk_sync_evt;

  // Only the mode and configuration fields are writable.
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cfg       <= rxb_pkg::rxb_cfg_t'(rxb_pkg::SELF_TEST_RESET[rxb_pkg::BIT_CFG_HI:rxb_pkg::BIT_CFG_LO]);
      wrap_mode <= rxb_pkg::SELF_TEST_RESET[rxb_pkg::BIT_WRAP_MODE];
    end else if (wr_self_test) begin
      cfg       <= rxb_pkg::rxb_cfg_t'(WDATA_IN[rxb_pkg::BIT_CFG_HI:rxb_pkg::BIT_CFG_LO]);
      wrap_mode <= WDATA_IN[rxb_pkg::BIT_WRAP_MODE];
    end
  end

  // Checker runs in codes 2 and 3 only; bit 13 is exactly that.
  // The enable needs no extra stage, because cfg is already a flop.
  assign CHECKER_EN_OUT = cfg[1];

  // Sync loss only means something while the checker runs.
  assign chk_sync_evt = CHK_SYNC_LOSS_IN && CHECKER_EN_OUT;

  // Sticky sync-loss; a new loss in the read cycle survives the clear.
  // A level on the loss input holds the bit set for as long as it stands.
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      sync_lost <= 1'b0;
    end else if (chk_sync_evt) begin
      sync_lost <= 1'b1;
    end else if (rd_self_test) begin
      sync_lost <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Packet generator control.
  // ----------------------------------------------------------------
  rxb_pkg::rxb_gen_state_t gen_state;
  rxb_pkg::rxb_gen_state_t next_gen_state;

  // A single packet is sent once per entry into code 1; software must leave
  // code 1 and return to send another, which keeps a stuck write from looping.
  always_comb begin
    next_gen_state = gen_state;
    unique case (gen_state)
      rxb_pkg::GS_IDLE: begin
        if (cfg == rxb_pkg::CFG_SINGLE) begin
          next_gen_state = rxb_pkg::GS_SINGLE;
        end else if (cfg == rxb_pkg::CFG_CONT) begin
          next_gen_state = rxb_pkg::GS_CONT;
        end
      end
      rxb_pkg::GS_SINGLE: begin
        if (cfg != rxb_pkg::CFG_SINGLE) begin
          next_gen_state = rxb_pkg::GS_IDLE;
        end else if (GEN_PKT_DONE_IN) begin
          next_gen_state = rxb_pkg::GS_SENT;
        end
      end
      rxb_pkg::GS_SENT: begin
        if (cfg != rxb_pkg::CFG_SINGLE) begin
          next_gen_state = rxb_pkg::GS_IDLE;
        end
      end
      rxb_pkg::GS_CONT: begin
        if (cfg != rxb_pkg::CFG_CONT) begin
          next_gen_state = rxb_pkg::GS_IDLE;
        end
      end
      default: begin
        next_gen_state = rxb_pkg::GS_IDLE;
      end
    endcase
  end

  // State and registered generator outputs.
  // Outputs use the next state, so they line up with gen_state.
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      gen_state    <= rxb_pkg::GS_IDLE;
      GEN_RUN_OUT  <= 1'b0;
      GEN_CONT_OUT <= 1'b0;
    end else begin
      gen_state    <= next_gen_state;
      GEN_RUN_OUT  <= (next_gen_state == rxb_pkg::GS_SINGLE) || (next_gen_state == rxb_pkg::GS_CONT);
      GEN_CONT_OUT <= (next_gen_state == rxb_pkg::GS_CONT);
    end
  end

  // ----------------------------------------------------------------
  // Counters.
  // ----------------------------------------------------------------
  logic [rxb_pkg::RX_ERR_W-1:0]  rx_count;
  logic                          rx_half_evt;
  logic [rxb_pkg::CHK_CNT_W-1:0] chk_count;
  logic                          chk_wrap;

  // Errors count only inside a valid carrier with data valid.
  // Loopback is gated inside the counter, next to the clear.
  rxb_rx_err_count u_rx_err (
    .clk          (MCLK_IN),
    .rst_n        (RST_N_IN),
    .err_in       (SYMBOL_ERR_IN && CARRIER_VALID_IN && RX_DV_IN),
    .loopback_in  (MII_LOOPBACK_IN),
    .clear_in     (rd_rx_err),
    .count_out    (rx_count),
    .half_evt_out (rx_half_evt)
  );

  // Checker errors count only while the checker is enabled.
  rxb_chk_err_count #(
    .W (rxb_pkg::CHK_CNT_W)
  ) u_chk_err (
    .clk            (MCLK_IN),
    .rst_n          (RST_N_IN),
    .enable_in      (CHECKER_EN_OUT),
    .err_in         (CHK_BIT_ERR_IN),
    .wrap_mode_in   (wrap_mode),
    .clear_in       (rd_chk_count),
    .count_out      (chk_count),
    .wrap_pulse_out (chk_wrap)
  );

  // The wrap pulse already leaves a flop inside the counter.
  assign CHK_WRAP_PULSE_OUT = chk_wrap;

  // ----------------------------------------------------------------
  // Interrupt status and mask.
  // ----------------------------------------------------------------
  logic [rxb_pkg::IRQ_W-1:0] irq_status;
  logic [rxb_pkg::IRQ_W-1:0] irq_mask;
  logic [rxb_pkg::IRQ_W-1:0] irq_events;
  logic [rxb_pkg::IRQ_W-1:0] next_irq_status;

  // Write-one-to-clear, with a same-cycle event winning over the clear.
  always_comb begin
    irq_events                         = '0;
    irq_events[rxb_pkg::IRQ_RX_HALF]   = rx_half_evt;
    irq_events[rxb_pkg::IRQ_CHK_WRAP]  = chk_wrap;
    irq_events[rxb_pkg::IRQ_SYNC_LOST] = chk_sync_evt;
    next_irq_status = irq_status;
    if (wr_irq_status) begin
      next_irq_status = irq_status & ~WDATA_IN[rxb_pkg::IRQ_W-1:0];
    end
    next_irq_status = next_irq_status | irq_events;
  end

  // Status bits, set by events and cleared by software.
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      irq_status <= '0;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // Mask bits let status bits reach the interrupt line.
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      irq_mask <= '0;
    end else if (wr_irq_mask) begin
      irq_mask <= WDATA_IN[rxb_pkg::IRQ_W-1:0];
    end
  end

  // Built from next values so the line tracks the status bits cycle for cycle.
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= |(next_irq_status & (wr_irq_mask ? WDATA_IN[rxb_pkg::IRQ_W-1:0] : irq_mask));
    end
  end

  // ----------------------------------------------------------------
  // Read data.
  // ----------------------------------------------------------------
  logic [rxb_pkg::DATA_W-1:0] self_test_view;

  // Reserved bits read as zero; the power-mode bit shows its normal-power value.
  always_comb begin
    self_test_view                                             = '0;
    self_test_view[rxb_pkg::BIT_WRAP_MODE]                     = wrap_mode;
    self_test_view[rxb_pkg::BIT_CFG_HI:rxb_pkg::BIT_CFG_LO]    = cfg;
    self_test_view[rxb_pkg::BIT_LOCKED]                        = CHK_LOCKED_IN && CHECKER_EN_OUT;
    self_test_view[rxb_pkg::BIT_SYNC_LOST]                     = sync_lost;
    self_test_view[rxb_pkg::BIT_GEN_STATUS]                    = GEN_RUN_OUT;
    self_test_view[rxb_pkg::BIT_POWER_MODE]                    = rxb_pkg::SELF_TEST_RESET[rxb_pkg::BIT_POWER_MODE];
  end

  // Data stand only in the cycle after the read strobe; unmapped reads give zero.
  // Clearing reads show the count as it stood before the clear.
  always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      RDATA_OUT <= '0;
    end else begin
      RDATA_OUT <= '0;
      if (RD_IN) begin
        unique case (ADDR_IN)
          rxb_pkg::ADDR_RX_ERR:     RDATA_OUT <= rx_count;
          rxb_pkg::ADDR_SELF_TEST:  RDATA_OUT <= self_test_view;
          rxb_pkg::ADDR_CHK_COUNT:  RDATA_OUT <= {{(rxb_pkg::DATA_W-rxb_pkg::CHK_CNT_W){1'b0}}, chk_count};
          rxb_pkg::ADDR_IRQ_STATUS: RDATA_OUT <= {{(rxb_pkg::DATA_W-rxb_pkg::IRQ_W){1'b0}}, irq_status};
          rxb_pkg::ADDR_IRQ_MASK:   RDATA_OUT <= {{(rxb_pkg::DATA_W-rxb_pkg::IRQ_W){1'b0}}, irq_mask};
          default:                  RDATA_OUT <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);

  // Software may rewrite the configuration at any edge, so generator checks only
  // look at outputs that the configuration already in place has fixed.
  sequence s_single_armed;
    gen_state == rxb_pkg::GS_SINGLE && cfg == rxb_pkg::CFG_SINGLE && GEN_PKT_DONE_IN;
  endsequence

  sequence s_single_quiet;
    (!GEN_RUN_OUT && !CHECKER_EN_OUT) ##1 !GEN_RUN_OUT;
  endsequence

  sequence s_single_entry;
    gen_state == rxb_pkg::GS_IDLE && cfg == rxb_pkg::CFG_SINGLE;
  endsequence

  sequence s_cont_left;
    gen_state == rxb_pkg::GS_CONT && cfg != rxb_pkg::CFG_CONT;
  endsequence

  chk_rx_read_clear: assert property (rd_rx_err && !SYMBOL_ERR_IN
    |=> RDATA_OUT == $past(rx_count) && rx_count == '0) else $error("rx count read did not clear");
  chk_cfg_off_check: assert property ((cfg == rxb_pkg::CFG_OFF || cfg == rxb_pkg::CFG_CHECK) [*2]
    |-> !GEN_RUN_OUT && CHECKER_EN_OUT == (cfg == rxb_pkg::CFG_CHECK)) else $error("enables wrong for code 0 or 2");
  chk_single_once: assert property (s_single_armed ##1 cfg == rxb_pkg::CFG_SINGLE |-> s_single_quiet)
    else $error("single packet mode kept running");
  chk_cont_run: assert property (cfg == rxb_pkg::CFG_CONT [*3] |-> GEN_RUN_OUT && GEN_CONT_OUT && CHECKER_EN_OUT)
    else $error("continuous mode not running");
  chk_lock_status: assert property (rd_self_test
    |=> RDATA_OUT[rxb_pkg::BIT_LOCKED] == $past(CHK_LOCKED_IN && CHECKER_EN_OUT)) else $error("lock bit wrong");
  chk_sync_set: assert property (chk_sync_evt |=> sync_lost [*2] or (sync_lost ##1 1'b1))
    else $error("sync loss not latched");
  chk_sync_sticky: assert property (sync_lost && !rd_self_test |=> sync_lost)
    else $error("sync loss dropped without read");
  chk_sync_clear: assert property (rd_self_test && !chk_sync_evt |=> !sync_lost)
    else $error("sync loss not cleared by read");
  chk_gen_status: assert property (rd_self_test
    |=> RDATA_OUT[rxb_pkg::BIT_GEN_STATUS] == $past(GEN_RUN_OUT)) else $error("generator status bit wrong");
  chk_irq_level: assert property (##1 IRQ_OUT == |(irq_status & irq_mask))
    else $error("interrupt line disagrees with status");
  chk_single_start: assert property (s_single_entry |=> GEN_RUN_OUT && !GEN_CONT_OUT)
    else $error("single packet mode did not start");
  chk_sent_quiet: assert property (gen_state == rxb_pkg::GS_SENT |-> !GEN_RUN_OUT && !GEN_CONT_OUT)
    else $error("generator ran after its single packet");
  chk_cont_stop: assert property (s_cont_left |=> !GEN_RUN_OUT && !GEN_CONT_OUT)
    else $error("generator kept running after code 3");
  chk_rx_ceiling: assert property (rx_count <= rxb_pkg::RX_ERR_MAX)
    else $error("rx count above its ceiling");
  chk_irq_set_wins: assert property (irq_events != '0
    |=> (irq_status & $past(irq_events)) == $past(irq_events))
    else $error("interrupt event lost");

endmodule : rxb_top

// ===== test/rxb_far_model.sv
/*
  Far-side model of the pattern generator and checker datapaths.
  Assumes it shares the block's clock and reset.
*/
`timescale 1ns/10ps
module rxb_far_model #(
  parameter int unsigned PKT_LEN = 20
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_n,
  // Controls from the block.
  input  wire logic gen_run_in,
  input  wire logic checker_en_in,
  // Status back to the block.
  output logic      done_out,
  output logic      locked_out
);
  logic [7:0] len;

  // A packet lasts PKT_LEN cycles and ends in one done pulse; the long packet shows the run level held.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      len      <= 8'h00;
      done_out <= 1'b0;
    end else begin
      done_out <= gen_run_in && (len == 8'(PKT_LEN - 1));
      len      <= (gen_run_in && len != 8'(PKT_LEN - 1)) ? len + 8'h01 : 8'h00;
    end
  end

  // The checker locks one cycle after it is enabled, so lock never precedes enable.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      locked_out <= 1'b0;
    end else begin
      locked_out <= checker_en_in;
    end
  end
endmodule : rxb_far_model

// ===== test/tb_top.sv
/*
  Self-checking bench for the receive error and self-test block.
  Assumes the far-side model drives lock and packet done.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_top;
  logic        mclk, rst_n, wr, rd, car, dv, serr, lb, sloss, berr;
  logic        irq, chk_en, wpulse, run, cont, done, locked;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, d;
  int          num_errors, checked, exp_rx, wraps, i;

  // Clock and wrap pulse tally.
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;
  always @(posedge mclk) if (wpulse === 1'b1) wraps++;

  rxb_top dut (.MCLK_IN(mclk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
    .RD_IN(rd), .RDATA_OUT(rdata), .CARRIER_VALID_IN(car), .RX_DV_IN(dv), .SYMBOL_ERR_IN(serr),
    .MII_LOOPBACK_IN(lb), .CHK_LOCKED_IN(locked), .CHK_SYNC_LOSS_IN(sloss), .CHK_BIT_ERR_IN(berr),
    .CHECKER_EN_OUT(chk_en), .CHK_WRAP_PULSE_OUT(wpulse), .GEN_PKT_DONE_IN(done),
    .GEN_RUN_OUT(run), .GEN_CONT_OUT(cont), .IRQ_OUT(irq));
  rxb_far_model #(.PKT_LEN(20)) far (.clk(mclk), .rst_n(rst_n), .gen_run_in(run),
    .checker_en_in(chk_en), .done_out(done), .locked_out(locked));

  // Bus cycles: one-cycle strobes, read data taken in the cycle after the strobe.
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
    @(posedge mclk);
    wr <= 1'b1; addr <= a; wdata <= v;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    @(posedge mclk);
    rd <= 1'b1; addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  // Error pulses separated by idle cycles; expected count saturates at 255.
  task automatic rx_burst(input int n, input bit rnd);
    logic [3:0] r;
    repeat (n) begin
      r = rnd ? 4'($urandom) : 4'he;
      @(posedge mclk);
      {car, dv, serr, lb} <= r;
      if (r == 4'he && exp_rx < 255) exp_rx++;
      @(posedge mclk);
      {car, dv, serr, lb} <= 4'h0;
    end
  endtask : rx_burst
  task automatic bit_errs(input int n);
    repeat (n) begin
      @(posedge mclk);
      berr <= 1'b1;
      @(posedge mclk);
      berr <= 1'b0;
    end
  endtask : bit_errs
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : settle
  task automatic summarize();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  // Expected self-test control word, built from the package field positions.
  function automatic logic [15:0] exp_ctl(input logic wrap, input logic [1:0] cfg, input logic lk,
                                          input logic lost, input logic gen);
    logic [15:0] v;
    v                                          = rxb_pkg::SELF_TEST_RESET;
    v[rxb_pkg::BIT_WRAP_MODE]                  = wrap;
    v[rxb_pkg::BIT_CFG_HI:rxb_pkg::BIT_CFG_LO] = cfg;
    v[rxb_pkg::BIT_LOCKED]                     = lk;
    v[rxb_pkg::BIT_SYNC_LOST]                  = lost;
    v[rxb_pkg::BIT_GEN_STATUS]                 = gen;
    return v;
  endfunction : exp_ctl

  // Watchdog sized well above the expected run length.
  initial begin
    #300us;
    num_errors++;
    summarize();
  end

  // Main sequence.
  initial begin
    {rst_n, wr, rd, car, dv, serr, lb, sloss, berr} = '0;
    addr = 8'h00; wdata = 16'h0000; exp_rx = 0; wraps = 0;
    void'($urandom(32'h1e7c735b));
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    rd_reg(8'h16); `CHK("ctl_reset", exp_ctl(1'b0, 2'h0, 1'b0, 1'b0, 1'b0), d)
    settle(1); `CHK("rdata_idle", 16'h0000, rdata)
    rd_reg(8'h40); `CHK("unmapped", 16'h0000, d)
    wr_reg(8'h1b, 16'h0007);
    // Half-full crossing, saturation and clear on read.
    rx_burst(127, 0); settle(3); `CHK("irq_low", 1'b0, irq)
    rx_burst(1, 0); settle(3); `CHK("irq_half", 1'b1, irq)
    rd_reg(8'h1a); `CHK("irq_stat", 16'h0001, d)
    wr_reg(8'h1a, 16'h0001); settle(2); `CHK("irq_clr", 1'b0, irq)
    rx_burst(200, 0); rd_reg(8'h15); `CHK("rx_sat", 16'h00ff, d)
    rd_reg(8'h15); `CHK("rx_cleared", 16'h0000, d)
    exp_rx = 0;
    rx_burst(600, 1); rd_reg(8'h15); `CHK("rx_rand", 16'(exp_rx), d)
    // An error in the clearing read cycle still counts once.
    @(posedge mclk);
    rd <= 1'b1; addr <= 8'h15; {car, dv, serr, lb} <= 4'he;
    @(posedge mclk);
    rd <= 1'b0; {car, dv, serr, lb} <= 4'h0;
    rd_reg(8'h15); `CHK("rx_rd_err", 16'h0001, d)
    // Checker only, stop mode then wrap mode.
    wr_reg(8'h16, 16'h2000); settle(2);
    `CHK("chk_en", 1'b1, chk_en)
    `CHK("gen_off", 1'b0, run)
    rd_reg(8'h16); `CHK("ctl_lock", exp_ctl(1'b0, 2'h2, 1'b1, 1'b0, 1'b0), d)
    bit_errs(300); rd_reg(8'h19); `CHK("chk_stop", 16'h00ff, d)
    wr_reg(8'h16, 16'h6000); bit_errs(255); settle(2); `CHK("no_wrap", 0, wraps)
    bit_errs(1); settle(2); `CHK("wrap", 1, wraps)
    rd_reg(8'h19); `CHK("chk_zero", 16'h0000, d)
    @(posedge mclk) sloss <= 1'b1;
    @(posedge mclk) sloss <= 1'b0;
    rd_reg(8'h16); `CHK("sync_lost", exp_ctl(1'b1, 2'h2, 1'b1, 1'b1, 1'b0), d)
    rd_reg(8'h16); `CHK("sync_rd_clr", exp_ctl(1'b1, 2'h2, 1'b1, 1'b0, 1'b0), d)
    rd_reg(8'h1a); `CHK("irq_stat2", 16'h0006, d)
    wr_reg(8'h1a, 16'h0007); rd_reg(8'h1a); `CHK("irq_w1c", 16'h0000, d)
    // Single packet: runs until done, then stays off.
    wr_reg(8'h16, 16'h1000); settle(2);
    `CHK("single_run", 1'b1, run)
    `CHK("single_nochk", 1'b0, chk_en)
    rd_reg(8'h16); `CHK("gen_stat", exp_ctl(1'b0, 2'h1, 1'b0, 1'b0, 1'b1), d)
    i = 0;
    while (run === 1'b1 && i < 60) begin @(posedge mclk); i++; end
    settle(30); `CHK("single_once", 1'b0, run)
    rd_reg(8'h16); `CHK("gen_stat_off", exp_ctl(1'b0, 2'h1, 1'b0, 1'b0, 1'b0), d)
    // Continuous generation with checker.
    wr_reg(8'h16, 16'h3000); settle(100);
    `CHK("cont_run", 1'b1, run)
    `CHK("cont_mode", 1'b1, cont)
    rd_reg(8'h16); `CHK("cont_stat", exp_ctl(1'b0, 2'h3, 1'b1, 1'b0, 1'b1), d)
    // Reserved bit write is ignored; config 0 turns all off.
    wr_reg(8'h16, 16'h8000); settle(3);
    `CHK("off_run", 1'b0, run)
    `CHK("off_chk", 1'b0, chk_en)
    rd_reg(8'h16); `CHK("ctl_off", exp_ctl(1'b0, 2'h0, 1'b0, 1'b0, 1'b0), d)
    summarize();
  end
endmodule : tb_top
